/* lesr_pkg.sv */
// Purpose: Constants for the lane equalizer setting register bank
// Assumes: Byte-wide register port, offsets 05h to 08h
// Notes:   Gain codes are 3 bits; 000 means no boost
package lesr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LESR_OFS_LANE0_LOW  = 8'h05;
  localparam logic [7:0] LESR_OFS_LANE0_HIGH = 8'h06;
  localparam logic [7:0] LESR_OFS_LANE1_LOW  = 8'h07;
  localparam logic [7:0] LESR_OFS_LANE1_HIGH = 8'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LESR_OVERRIDE_BIT = 7;
  localparam int LESR_UPPER_LSB    = 4;
  localparam int LESR_LOWER_LSB    = 0;
  localparam int LESR_GAIN_W       = 3;
  localparam int LESR_LANES        = 2;

  // Bits that hold state; the rest read as zero
  localparam logic [7:0] LESR_LOW_MASK  = 8'hf7;
  localparam logic [7:0] LESR_HIGH_MASK = 8'h77;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] LESR_GAIN_RESET     = 3'h0;
  localparam logic       LESR_OVERRIDE_RESET = 1'b0;

  // Selection modes of the gain mux
  typedef enum logic [1:0] {
    LESR_MODE_PINS,
    LESR_MODE_FIXED,
    LESR_MODE_TRAINED
  } lesr_mode_type;

endpackage

/* lesr_lane_select.sv */
// Purpose: Per-lane gain code selection
// Assumes: All inputs are on core_clk
// Notes:   Registered output, one cycle behind its inputs
`timescale 1ns/100ps
module lesr_lane_select
  import lesr_pkg::*;
(
  input  wire logic                   core_clk,   // Core clock
  input  wire logic                   rst_n,      // Sync reset, active low
  input  wire lesr_mode_type          mode,       // Selection mode
  input  wire logic [1:0]             level,      // Trained pre-emphasis level
  input  wire logic [LESR_GAIN_W-1:0] pin_gain,   // Gain from device inputs
  input  wire logic [4*LESR_GAIN_W-1:0] fields,   // Level 3..0 register codes
  output logic      [LESR_GAIN_W-1:0] gain        // Selected gain code
);

  logic [LESR_GAIN_W-1:0] next_gain;

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Mux picks pins, fixed level-one code, or trained-level code
  always_comb
  begin
    next_gain = pin_gain;
    unique case (mode)
      LESR_MODE_PINS:    next_gain = pin_gain;
      LESR_MODE_FIXED:   next_gain = fields[LESR_GAIN_W +: LESR_GAIN_W];
      LESR_MODE_TRAINED: next_gain = fields[level*LESR_GAIN_W +: LESR_GAIN_W];
      default:           next_gain = pin_gain;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      gain <= LESR_GAIN_RESET;
    else
      gain <= next_gain;
  end

endmodule

/* lesr_bank.sv */
// Purpose: Equalizer gain register bank for main-link lanes 0 and 1
// Assumes: Register port strobes come from the serial interface on core_clk
// Notes:   Gain codes 001..111 are passed through; meaning depends on rate
`timescale 1ns/100ps
module lesr_bank
  import lesr_pkg::*;
(
  input  wire logic                   core_clk,        // Core clock, 10 MHz
  input  wire logic                   rst_n,           // Sync reset, active low
  input  wire logic [7:0]             reg_addr,        // Register offset
  input  wire logic [7:0]             reg_wdata,       // Write data
  input  wire logic                   reg_wr,          // Write strobe
  input  wire logic                   reg_rd,          // Read strobe
  output logic      [7:0]             reg_rdata,       // Read data
  input  wire logic                   tmds_sink_sel,   // TMDS sink selected
  input  wire logic                   training_enable, // Link training enabled
  input  wire logic [1:0]             lane0_level,     // Lane 0 trained level
  input  wire logic [1:0]             lane1_level,     // Lane 1 trained level
  input  wire logic [LESR_GAIN_W-1:0] lane0_pin_gain,  // Lane 0 pin gain code
  input  wire logic [LESR_GAIN_W-1:0] lane1_pin_gain,  // Lane 1 pin gain code
  output logic                        register_gain_override, // Override bit
  output logic      [LESR_GAIN_W-1:0] lane0_gain,      // Lane 0 selected code
  output logic      [LESR_GAIN_W-1:0] lane1_gain       // Lane 1 selected code
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] eq_override_lane0_low_levels;
  logic [7:0] lane0_high_levels_gain;
  logic [7:0] lane1_low_levels_gain;
  logic [7:0] lane1_high_levels_gain;
  logic [7:0] next_lane0_low;
  logic [7:0] next_lane0_high;
  logic [7:0] next_lane1_low;
  logic [7:0] next_lane1_high;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Masks drop writes to undescribed bits. A write and a read in the
  // same cycle are both taken: the read sees the old byte and the write
  // lands at the edge, so the host never gets a half-updated value.
  always_comb
  begin
    next_lane0_low  = eq_override_lane0_low_levels;
    next_lane0_high = lane0_high_levels_gain;
    next_lane1_low  = lane1_low_levels_gain;
    next_lane1_high = lane1_high_levels_gain;
    if (reg_wr)
    begin
      unique case (reg_addr)
        LESR_OFS_LANE0_LOW:  next_lane0_low  = reg_wdata & LESR_LOW_MASK;
        LESR_OFS_LANE0_HIGH: next_lane0_high = reg_wdata & LESR_HIGH_MASK;
        LESR_OFS_LANE1_LOW:  next_lane1_low  = reg_wdata & LESR_HIGH_MASK;
        LESR_OFS_LANE1_HIGH: next_lane1_high = reg_wdata & LESR_HIGH_MASK;
        default:             next_lane0_low  = eq_override_lane0_low_levels;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      eq_override_lane0_low_levels <= {LESR_OVERRIDE_RESET, LESR_GAIN_RESET,
                                       1'b0, LESR_GAIN_RESET};
      lane0_high_levels_gain       <= {1'b0, LESR_GAIN_RESET, 1'b0, LESR_GAIN_RESET};
      lane1_low_levels_gain        <= {1'b0, LESR_GAIN_RESET, 1'b0, LESR_GAIN_RESET};
      lane1_high_levels_gain       <= {1'b0, LESR_GAIN_RESET, 1'b0, LESR_GAIN_RESET};
    end
    else
    begin
      eq_override_lane0_low_levels <= next_lane0_low;
      lane0_high_levels_gain       <= next_lane0_high;
      lane1_low_levels_gain        <= next_lane1_low;
      lane1_high_levels_gain       <= next_lane1_high;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read zero; data held between reads
  always_comb
  begin
    next_rdata = reg_rdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        LESR_OFS_LANE0_LOW:  next_rdata = eq_override_lane0_low_levels;
        LESR_OFS_LANE0_HIGH: next_rdata = lane0_high_levels_gain;
        LESR_OFS_LANE1_LOW:  next_rdata = lane1_low_levels_gain;
        LESR_OFS_LANE1_HIGH: next_rdata = lane1_high_levels_gain;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic          override;
  lesr_mode_type mode;
  logic          next_override;

  assign override = eq_override_lane0_low_levels[LESR_OVERRIDE_BIT];

  // TMDS wins over training state; training off falls back to fixed gain
  always_comb
  begin
    if (!override)
      mode = LESR_MODE_PINS;
    else if (tmds_sink_sel)
      mode = LESR_MODE_FIXED;
    else if (!training_enable)
      mode = LESR_MODE_FIXED;
    else
      mode = LESR_MODE_TRAINED;
    next_override = override;
  end

  // Registered copy, so every top output comes straight from a flop
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      register_gain_override <= LESR_OVERRIDE_RESET;
    else
      register_gain_override <= next_override;
  end

  // ----------------------------------------------------------------
  // Named gain fields
  // ----------------------------------------------------------------
  // One name per stored code keeps the field map in a single place
  logic [LESR_GAIN_W-1:0] lane_zero_level_zero_gain;
  logic [LESR_GAIN_W-1:0] lane_zero_level_one_gain;
  logic [LESR_GAIN_W-1:0] lane_zero_level_two_gain;
  logic [LESR_GAIN_W-1:0] lane_zero_level_three_gain;
  logic [LESR_GAIN_W-1:0] lane_one_level_zero_gain;
  logic [LESR_GAIN_W-1:0] lane_one_level_one_gain;
  logic [LESR_GAIN_W-1:0] lane_one_level_two_gain;
  logic [LESR_GAIN_W-1:0] lane_one_level_three_gain;

  // Lane 0: levels 0 and 1 in 05h, levels 2 and 3 in 06h
  assign lane_zero_level_zero_gain  =
    eq_override_lane0_low_levels[LESR_UPPER_LSB +: LESR_GAIN_W];
  assign lane_zero_level_one_gain   =
    eq_override_lane0_low_levels[LESR_LOWER_LSB +: LESR_GAIN_W];
  assign lane_zero_level_two_gain   =
    lane0_high_levels_gain[LESR_UPPER_LSB +: LESR_GAIN_W];
  assign lane_zero_level_three_gain =
    lane0_high_levels_gain[LESR_LOWER_LSB +: LESR_GAIN_W];

  // Lane 1: levels 0 and 1 in 07h, levels 2 and 3 in 08h
  assign lane_one_level_zero_gain   =
    lane1_low_levels_gain[LESR_UPPER_LSB +: LESR_GAIN_W];
  assign lane_one_level_one_gain    =
    lane1_low_levels_gain[LESR_LOWER_LSB +: LESR_GAIN_W];
  assign lane_one_level_two_gain    =
    lane1_high_levels_gain[LESR_UPPER_LSB +: LESR_GAIN_W];
  assign lane_one_level_three_gain  =
    lane1_high_levels_gain[LESR_LOWER_LSB +: LESR_GAIN_W];

  // ----------------------------------------------------------------
  // Per-lane selection
  // ----------------------------------------------------------------
  // Field vectors ordered level 3..0; codes pass unchanged
  logic [4*LESR_GAIN_W-1:0] lane_fields [LESR_LANES];
  logic [1:0]               lane_level  [LESR_LANES];
  logic [LESR_GAIN_W-1:0]   lane_pin    [LESR_LANES];
  logic [LESR_GAIN_W-1:0]   lane_gain   [LESR_LANES];

  assign lane_fields[0] = {lane_zero_level_three_gain, lane_zero_level_two_gain,
                           lane_zero_level_one_gain, lane_zero_level_zero_gain};
  assign lane_fields[1] = {lane_one_level_three_gain, lane_one_level_two_gain,
                           lane_one_level_one_gain, lane_one_level_zero_gain};
  assign lane_level[0]  = lane0_level;
  assign lane_level[1]  = lane1_level;
  assign lane_pin[0]    = lane0_pin_gain;
  assign lane_pin[1]    = lane1_pin_gain;

  genvar g;
  generate
    for (g = 0; g < LESR_LANES; g++)
    begin : g_lane
      lesr_lane_select u_sel (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .mode     (mode),
        .level    (lane_level[g]),
        .pin_gain (lane_pin[g]),
        .fields   (lane_fields[g]),
        .gain     (lane_gain[g])
      );
    end
  endgenerate

  assign lane0_gain = lane_gain[0];
  assign lane1_gain = lane_gain[1];

endmodule

/* lesr_chk.sv */
// Purpose: Port checker for the equalizer gain register bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Keeps a masked shadow of 05h..08h to predict outputs
`timescale 1ns/100ps
module lesr_chk
  import lesr_pkg::*;
(
  input wire logic                   core_clk,               // Clock
  input wire logic                   rst_n,                  // Reset, active low
  input wire logic [7:0]             reg_addr,               // Offset
  input wire logic [7:0]             reg_wdata,              // Write data
  input wire logic                   reg_wr,                 // Write strobe
  input wire logic                   reg_rd,                 // Read strobe
  input wire logic [7:0]             reg_rdata,              // Read data
  input wire logic                   tmds_sink_sel,          // TMDS sink
  input wire logic                   training_enable,        // Training on
  input wire logic [1:0]             lane0_level,            // Lane 0 level
  input wire logic [1:0]             lane1_level,            // Lane 1 level
  input wire logic [LESR_GAIN_W-1:0] lane0_pin_gain,         // Lane 0 pin code
  input wire logic [LESR_GAIN_W-1:0] lane1_pin_gain,         // Lane 1 pin code
  input wire logic                   register_gain_override, // Override
  input wire logic [LESR_GAIN_W-1:0] lane0_gain,             // Lane 0 code
  input wire logic [LESR_GAIN_W-1:0] lane1_gain              // Lane 1 code
);
  logic [7:0] sh [4];
  wire logic       hit = reg_addr >= 8'h05 && reg_addr <= 8'h08;
  wire logic [1:0] idx = reg_addr[1:0] - 2'h1;
  wire logic [7:0] rexp = hit ? sh[idx] : 8'h00;
  wire logic       ovr = sh[0][7];
  // Shadow stores only the described bits, so reads predict zeros
  always_ff @(posedge core_clk)
    if (!rst_n)
      sh <= '{default: 8'h00};
    else if (reg_wr && hit)
      sh[idx] <= reg_wdata & ((idx == 2'h0) ? 8'hf7 : 8'h77);
  // Trained level picks one of four codes
  function automatic logic [2:0] pick(logic [7:0] lo, logic [7:0] hi, logic [1:0] l);
    return l[1] ? (l[0] ? hi[2:0] : hi[6:4]) : (l[0] ? lo[2:0] : lo[6:4]);
  endfunction
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_ovr; $past(rst_n) |-> register_gain_override == $past(ovr); endproperty
  property p_pins; $past(rst_n && !ovr) |-> lane0_gain == $past(lane0_pin_gain)
    && lane1_gain == $past(lane1_pin_gain); endproperty
  property p_tmds; $past(rst_n && ovr && tmds_sink_sel) |-> lane0_gain == $past(sh[0][2:0])
    && lane1_gain == $past(sh[2][2:0]); endproperty
  property p_fix; $past(rst_n && ovr && !tmds_sink_sel && !training_enable)
    |-> lane0_gain == $past(sh[0][2:0]) && lane1_gain == $past(sh[2][2:0]); endproperty
  property p_tr0; $past(rst_n && ovr && !tmds_sink_sel && training_enable)
    |-> lane0_gain == $past(pick(sh[0], sh[1], lane0_level)); endproperty
  property p_tr1; $past(rst_n && ovr && !tmds_sink_sel && training_enable)
    |-> lane1_gain == $past(pick(sh[2], sh[3], lane1_level)); endproperty
  property p_rd; reg_rd |=> reg_rdata == $past(rexp); endproperty
  property p_rst; $rose(rst_n) |-> lane0_gain == 3'h0 && lane1_gain == 3'h0
    && reg_rdata == 8'h00 && !register_gain_override; endproperty
  a_ovr: assert property (p_ovr) else $error("override bit wrong");
  a_pins: assert property (p_pins) else $error("pin code not passed");
  a_tmds: assert property (p_tmds) else $error("sink fixed code wrong");
  a_fix: assert property (p_fix) else $error("fixed code wrong");
  a_tr0: assert property (p_tr0) else $error("lane 0 code wrong");
  a_tr1: assert property (p_tr1) else $error("lane 1 code wrong");
  a_rd: assert property (p_rd) else $error("read data wrong");
  a_rst: assert property (p_rst) else $error("reset value wrong");
  c_tr: cover property (ovr && training_enable && !tmds_sink_sel && lane0_level == 2'h3);
  c_tmds: cover property (ovr && tmds_sink_sel);
  c_rd: cover property (reg_rd && reg_addr == 8'h09);
endmodule

/* lesr_host.sv */
// Purpose: Host model for the register strobe port
// Assumes: Drives just after the falling edge of core_clk
// Notes:   Idle lines show the inverse of the last value
`timescale 1ns/100ps
module lesr_host
(
  input  wire logic       core_clk,  // Clock
  output logic      [7:0] reg_addr,  // Offset
  output logic      [7:0] reg_wdata, // Write data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  input  wire logic [7:0] reg_rdata  // Read data
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write pulse, then stale-looking lines
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the equalizer gain register bank
// Assumes: Host model drives the register port
// Notes:   Gains are checked one edge after each change
`timescale 1ns/100ps
module tb;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       tmds_sink_sel = 1'b0;
  logic       training_enable = 1'b1;
  logic [1:0] lane0_level = 2'h0;
  logic [1:0] lane1_level = 2'h0;
  logic [2:0] lane0_pin_gain = 3'h5;
  logic [2:0] lane1_pin_gain = 3'h2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, register_gain_override;
  logic [2:0] lane0_gain, lane1_gain;
  logic [2:0] t0 [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  logic [2:0] t1 [4] = '{3'h5, 3'h6, 3'h7, 3'h1};
  int         err_count = 0;
  int         n_tests = 0;
  int         cyc = 0;
  lesr_bank uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tmds_sink_sel, .training_enable, .lane0_level, .lane1_level, .lane0_pin_gain,
    .lane1_pin_gain, .register_gain_override, .lane0_gain, .lane1_gain);
  lesr_host host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    cmp(d, e);
  endtask
  // Both lanes and the override copy packed into one byte compare
  task automatic gain_chk(input logic [2:0] e0, input logic [2:0] e1, input logic eo);
    @(negedge core_clk);
    cmp({register_gain_override, lane1_gain, 1'b0, lane0_gain}, {eo, e1, 1'b0, e0});
  endtask
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      stop_test;
    end
  end
  initial
  begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 5; i <= 8; i++)
      rd_chk(i[7:0], 8'h00);
    gain_chk(3'h5, 3'h2, 1'b0);
    $display("test reset done");
    for (int i = 4; i <= 9; i++)
      host.wr(i[7:0], 8'hff);
    for (int i = 4; i <= 9; i++)
      rd_chk(i[7:0], (i == 4 || i == 9) ? 8'h00 : (i == 5) ? 8'hf7 : 8'h77);
    $display("test mask done");
    host.wr(8'h05, 8'h92);
    host.wr(8'h06, 8'h34);
    host.wr(8'h07, 8'h56);
    host.wr(8'h08, 8'h71);
    for (int l = 0; l < 4; l++)
    begin
      lane0_level = l[1:0];
      lane1_level = 2'h3 - l[1:0];
      gain_chk(t0[l], t1[3 - l], 1'b1);
    end
    training_enable = 1'b0;
    gain_chk(3'h2, 3'h6, 1'b1);
    training_enable = 1'b1;
    tmds_sink_sel = 1'b1;
    gain_chk(3'h2, 3'h6, 1'b1);
    $display("test modes done");
    for (int c = 1; c < 8; c++)
    begin
      host.wr(8'h05, {5'h10, c[2:0]});
      gain_chk(c[2:0], 3'h6, 1'b1);
    end
    tmds_sink_sel = 1'b0;
    host.wr(8'h05, 8'h12);
    lane0_pin_gain = 3'h7;
    lane1_pin_gain = 3'h1;
    gain_chk(3'h7, 3'h1, 1'b0);
    rd_chk(8'h05, 8'h12);
    $display("test codes done");
    // Second reset with nonzero registers, so the reset values really show
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 5; i <= 8; i++)
      rd_chk(i[7:0], 8'h00);
    gain_chk(3'h7, 3'h1, 1'b0);
    $display("test second reset done");
    stop_test;
  end
endmodule
bind lesr_bank lesr_chk chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .tmds_sink_sel, .training_enable, .lane0_level, .lane1_level,
  .lane0_pin_gain, .lane1_pin_gain, .register_gain_override, .lane0_gain, .lane1_gain);
